/* File: hdl/stdc_top.sv */
/*
 * System tick down counter with an APB register slave.
 * Assumes an APB master on clk_in; no interrupt, no second clock.
 */
// How it works
// - 24-bit down counter, wraps at zero, cleared by software write.
// - while enabled, count drops by one each clock down to zero.
// - clock after reaching zero, reload value loads, counting continues.
// - wrap status flag sets one clock after count steps onto zero.
// - reading the control/status register clears the wrap status flag.
// - any write to current count register clears count to zero.
// - count is not reset; its value after reset is unknown.
// - reload value zero keeps the count at zero after reload.
module stdc_top (
   input  wire logic                  clk_in,
   input  wire logic                  reset_n_in,
   input  wire logic                  ce_in,
   input  wire stdc_pkg::stdc_apb_req_t apb_req_in,
   output stdc_pkg::stdc_apb_rsp_t    apb_rsp_out,
   output logic [23:0]                current_count_value_out,
   output logic                       wrap_status_flag_out
);
   import stdc_pkg::*;

   logic                  enable_r;
   logic [STDC_CNT_W-1:0] reload_value_r;
   logic                  wrap_status_flag_r;
   logic                  wrap_status_flag_nxt;
   stdc_apb_rsp_t         rsp_r;
   stdc_apb_rsp_t         rsp_nxt;
   logic [STDC_CNT_W-1:0] count_w;
   logic                  wrap_w;
   logic                  access_w;
   logic                  wr_w;
   logic                  rd_w;
   logic                  clear_w;
   logic [STDC_CNT_W-1:0] count_shown_r;

   ////////////////////////////////////////////////////////////////////////////
   // apb access strobes: one cycle wait, answer in the second access cycle
   assign access_w = apb_req_in.psel && apb_req_in.penable && !rsp_r.pready;
   assign wr_w     = access_w && apb_req_in.pwrite;
   assign rd_w     = access_w && !apb_req_in.pwrite;
   assign clear_w  = wr_w && (apb_req_in.paddr == STDC_CURR_OFS);

   stdc_counter #(
      .CNT_W (STDC_CNT_W)
   ) u_counter (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .ce_in      (ce_in),
      .enable_in  (enable_r),
      .clear_in   (clear_w),
      .reload_in  (reload_value_r),
      .count_out  (count_w),
      .wrap_out   (wrap_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // software-written control and reload
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         enable_r       <= STDC_ENABLE_RST;
         reload_value_r <= STDC_RELOAD_RST;
      end else if (ce_in && wr_w) begin
         if (apb_req_in.paddr == STDC_CTRL_OFS) begin
            enable_r <= apb_req_in.pwdata[STDC_ENABLE_BIT];
         end
         if (apb_req_in.paddr == STDC_RELOAD_OFS) begin
            reload_value_r <= apb_req_in.pwdata[STDC_CNT_W-1:0];
         end
      end
   end

   // wrap flag: a new wrap wins over the clear-on-read
   always_comb begin
      wrap_status_flag_nxt = wrap_status_flag_r;
      if (rd_w && apb_req_in.paddr == STDC_CTRL_OFS) begin
         wrap_status_flag_nxt = 1'b0;
      end
      if (wrap_w) begin
         wrap_status_flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wrap_status_flag_r <= 1'b0;
      end else if (ce_in) begin
         wrap_status_flag_r <= wrap_status_flag_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data and ready; unmapped addresses answer pslverr
   always_comb begin
      rsp_nxt = '0;
      if (access_w) begin
         rsp_nxt.pready = 1'b1;
         case (apb_req_in.paddr)
            STDC_CTRL_OFS: begin
               rsp_nxt.prdata[STDC_ENABLE_BIT] = enable_r;
               rsp_nxt.prdata[STDC_WRAP_BIT]   = wrap_status_flag_r;
            end
            STDC_RELOAD_OFS: begin
               rsp_nxt.prdata[STDC_CNT_W-1:0] = reload_value_r;
            end
            STDC_CURR_OFS: begin
               rsp_nxt.prdata[STDC_CNT_W-1:0] = count_w;
            end
            default: begin
               rsp_nxt.pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rsp_r <= '0;
      end else if (ce_in) begin
         rsp_r <= rsp_nxt;
      end
   end

   // registered copy of the count for the output pins
   always_ff @(posedge clk_in) begin
      if (ce_in) begin
         count_shown_r <= count_w;
      end
   end

   assign apb_rsp_out             = rsp_r;
   assign current_count_value_out = count_shown_r;
   assign wrap_status_flag_out    = wrap_status_flag_r;
endmodule

/* File: hdl/stdc_pkg.sv */
/*
 * Shared constants and carriers for the system tick down counter.
 * Assumes a 32-bit APB slave port and one 250 MHz clock domain.
 */
package stdc_pkg;

   // register byte offsets
   localparam logic [11:0] STDC_CTRL_OFS   = 12'h000;
   localparam logic [11:0] STDC_RELOAD_OFS = 12'h004;
   localparam logic [11:0] STDC_CURR_OFS   = 12'h008;

   // control and status field positions
   localparam int STDC_ENABLE_BIT = 0;
   localparam int STDC_WRAP_BIT   = 16;

   // widths and reset values
   localparam int          STDC_CNT_W     = 24;
   localparam logic [23:0] STDC_RELOAD_RST = 24'h000000;
   localparam logic        STDC_ENABLE_RST = 1'b0;

   // apb request carrier
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } stdc_apb_req_t;

   // apb answer carrier
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } stdc_apb_rsp_t;

endpackage

/* File: hdl/stdc_counter.sv */
/*
 * 24-bit down counter core with reload, wrap detect and clear.
 * Assumes one clock, an active-low asynchronous reset and a clock enable.
 */
module stdc_counter #(
   parameter int CNT_W = 24
) (
   input  wire logic             clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             ce_in,
   input  wire logic             enable_in,
   input  wire logic             clear_in,
   input  wire logic [CNT_W-1:0] reload_in,
   output logic      [CNT_W-1:0] count_out,
   output logic                  wrap_out
);
   import stdc_pkg::*;

   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic             wrap_r;
   logic             wrap_nxt;

   // refuse widths the decrement and the 32-bit read path cannot serve
   if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
      $error("stdc_counter: CNT_W must lie in 2..32");
   end

   ////////////////////////////////////////////////////////////////////////////
   // next count: clear, reload at zero, or decrement
   always_comb begin
      count_nxt = count_r;
      wrap_nxt  = 1'b0;
      if (clear_in) begin
         count_nxt = '0;
      end else if (enable_in) begin
         if (count_r == '0) begin
            count_nxt = reload_in;
         end else begin
            count_nxt = count_r - 1'b1;
            wrap_nxt  = (count_r == {{(CNT_W-1){1'b0}}, 1'b1});
         end
      end
   end

   // count carries no reset: its value after reset is undefined
   always_ff @(posedge clk_in) begin
      if (ce_in) begin
         count_r <= count_nxt;
      end
   end

   // one-cycle pulse when the count steps onto zero
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wrap_r <= 1'b0;
      end else if (ce_in) begin
         wrap_r <= wrap_nxt;
      end
   end

   assign count_out = count_r;
   assign wrap_out  = wrap_r;
endmodule

/* File: verif/stdc_top_chk.sv */
/* port checker for the tick counter.
   assumes ce_in held high and a bench that never clears the count as it steps 1 to 0. */
module stdc_top_chk (
   input wire logic                    clk_in,
   input wire logic                    reset_n_in,
   input wire stdc_pkg::stdc_apb_req_t apb_req_in,
   input wire stdc_pkg::stdc_apb_rsp_t apb_rsp_out,
   input wire logic [23:0]             current_count_value_out,
   input wire logic                    wrap_status_flag_out
);
   import stdc_pkg::*;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   logic [23:0] cnt, rl_r;
   logic        acc, rd_ctl, wr_cur, wr_ctl, en_r;
   logic [1:0]  idle_r;
   logic        known_r;
   assign cnt    = current_count_value_out;
   assign acc    = apb_req_in.psel & apb_req_in.penable & ~apb_rsp_out.pready;
   assign rd_ctl = acc & ~apb_req_in.pwrite & (apb_req_in.paddr == STDC_CTRL_OFS);
   assign wr_cur = acc & apb_req_in.pwrite & (apb_req_in.paddr == STDC_CURR_OFS);
   assign wr_ctl = acc & apb_req_in.pwrite & (apb_req_in.paddr == STDC_CTRL_OFS);
   // shadow of enable and reload, and a count of quiet disabled cycles
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         en_r   <= 1'b0;
         rl_r   <= 24'h000000;
         idle_r <= 2'h0;
         known_r <= 1'b0;
      end else begin
         // count is only defined once software has cleared it
         if (wr_cur) known_r <= 1'b1;
         if (wr_ctl) en_r <= apb_req_in.pwdata[0];
         if (acc & apb_req_in.pwrite & (apb_req_in.paddr == STDC_RELOAD_OFS)) rl_r <= apb_req_in.pwdata[23:0];
         if (en_r | wr_cur) idle_r <= 2'h0;
         else if (idle_r != 2'h3) idle_r <= idle_r + 2'h1;
      end
   end
   ////////////////////////////////////////////////////////////////
   chk_step_down: assert property ($past(cnt) != 24'h0 && cnt != $past(cnt) |->
      cnt == $past(cnt) - 24'h1 || cnt == 24'h0) else $error("count moved by more than one");
   chk_wrap_reload: assert property ($past(cnt) == 24'h0 && cnt != 24'h0 |->
      cnt == $past(rl_r, 2)) else $error("count left zero without reload value");
   chk_flag_set: assert property ($past(cnt) == 24'h1 && cnt == 24'h0 |->
      ##[0:1] wrap_status_flag_out) else $error("wrap flag not set");
   chk_flag_read: assert property (rd_ctl |=> apb_rsp_out.pready &&
      apb_rsp_out.prdata[16] == $past(wrap_status_flag_out)) else $error("flag read wrong");
   chk_flag_clear: assert property (rd_ctl && cnt > 24'h2 |=> !wrap_status_flag_out)
      else $error("flag not cleared by read");
   chk_write_clear: assert property (wr_cur |=> ##1 cnt == 24'h0)
      else $error("count not cleared by write");
   chk_hold_idle: assert property (idle_r == 2'h3 && known_r |-> $stable(cnt))
      else $error("count moved while disabled");
   chk_zero_hold: assert property (cnt == 24'h0 && rl_r == 24'h0 && $past(rl_r) == 24'h0 |=>
      cnt == 24'h0) else $error("count left zero with zero reload");
   chk_count_width: assert property (acc && !apb_req_in.pwrite && apb_req_in.paddr == STDC_CURR_OFS |=>
      apb_rsp_out.pready && apb_rsp_out.prdata[31:24] == 8'h00) else $error("count wider than 24 bits");
endmodule

/* File: verif/tb_stdc_top.sv */
/* self-checking bench for the tick counter over apb.
   assumes the checker file is compiled before this top. */
module tb_stdc_top;
   timeunit 1ns;
   timeprecision 100ps;
   import stdc_pkg::*;
   logic          clk_in     = 1'b0;
   logic          reset_n_in = 1'b0;
   stdc_apb_req_t req        = '0;
   stdc_apb_rsp_t rsp;
   logic [23:0]   cnt;
   logic          wrap, err;
   logic [31:0]   rd, v;
   int            err_count = 0, comparisons = 0, cyc = 0;
   always #2 clk_in = ~clk_in;
   stdc_top i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(1'b1), .apb_req_in(req),
      .apb_rsp_out(rsp), .current_count_value_out(cnt), .wrap_status_flag_out(wrap));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one apb transfer, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_in);
      req.penable <= 1'b1;
      do @(posedge clk_in); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      @(posedge clk_in);
   endtask
   task automatic wait_one;
      do @(posedge clk_in); while (cnt !== 24'h000001);
   endtask
   ////////////////////////////////////////////////////////////////
   task t_regs;
      apb(1'b0, STDC_CTRL_OFS, 32'h0); chk(rd, 32'h00000000);
      apb(1'b1, STDC_RELOAD_OFS, 32'hffabcdef); apb(1'b0, STDC_RELOAD_OFS, 32'h0); chk(rd, 32'h00abcdef);
      apb(1'b0, 12'h00c, 32'h0); chk({rd[31:1], err}, 32'h00000001);
   endtask
   task t_run;
      apb(1'b1, STDC_CURR_OFS, 32'hdeadbeef); apb(1'b0, STDC_CURR_OFS, 32'h0); chk(rd, 32'h0);
      apb(1'b1, STDC_RELOAD_OFS, 32'h20); apb(1'b1, STDC_CTRL_OFS, 32'h1);
      wait_one();
      @(posedge clk_in); chk({8'h0, cnt}, 32'h0);
      @(posedge clk_in); chk({8'h0, cnt}, 32'h20);
      @(posedge clk_in); chk({8'h0, cnt}, 32'h1f);
      chk({31'h0, wrap}, 32'h1);
      apb(1'b0, STDC_CTRL_OFS, 32'h0); chk(rd, 32'h00010001);
      apb(1'b0, STDC_CTRL_OFS, 32'h0); chk(rd, 32'h00000001);
      chk({31'h0, wrap}, 32'h0);
      apb(1'b1, STDC_RELOAD_OFS, 32'h0);
      wait_one();
      repeat (8) @(posedge clk_in);
      chk({8'h0, cnt}, 32'h0);
   endtask
   task t_hold;
      apb(1'b1, STDC_RELOAD_OFS, 32'h10); apb(1'b1, STDC_CTRL_OFS, 32'h0);
      apb(1'b0, STDC_CURR_OFS, 32'h0); v = rd;
      repeat (10) @(posedge clk_in);
      apb(1'b0, STDC_CURR_OFS, 32'h0); chk(rd, v);
      apb(1'b1, STDC_CURR_OFS, 32'h5); apb(1'b0, STDC_CURR_OFS, 32'h0); chk(rd, 32'h0);
   endtask
   // cycle ceiling cuts a hang short
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         conclude();
      end
   end
   // reset, then the scenarios in turn
   initial begin
      repeat (3) @(posedge clk_in);
      reset_n_in <= 1'b1;
      @(posedge clk_in);
      t_regs();
      t_run();
      t_hold();
      conclude();
   end
endmodule
bind stdc_top stdc_top_chk i_chk (.clk_in(clk_in), .reset_n_in(reset_n_in), .apb_req_in(apb_req_in),
   .apb_rsp_out(apb_rsp_out), .current_count_value_out(current_count_value_out),
   .wrap_status_flag_out(wrap_status_flag_out));
